// [logic/cca_pkg.sv]
`default_nettype none
package cca_pkg;
   // =========================================
   // Register bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;

   // =========================================
   // Register offsets
   localparam logic [7:0] ADDR_CONTROL       = 8'h00;
   localparam logic [7:0] ADDR_ALERT_ENABLE  = 8'h01;
   localparam logic [7:0] ADDR_ALERT_FLAGS   = 8'h02;
   localparam logic [7:0] ADDR_ACCUMULATOR   = 8'h03;
   localparam logic [7:0] ADDR_UPPER_LIMIT   = 8'h04;
   localparam logic [7:0] ADDR_LOWER_LIMIT   = 8'h05;
   localparam logic [7:0] ADDR_PRESCALE      = 8'h06;
   localparam logic [7:0] ADDR_CHARGE_TARGET = 8'h07;
   localparam logic [7:0] ADDR_BAT_VOLTAGE   = 8'h08;
   localparam logic [7:0] ADDR_CHARGE_CURR   = 8'h09;
   localparam logic [7:0] ADDR_INPUT_CURR    = 8'h0A;
   localparam logic [7:0] ADDR_DIE_TEMP      = 8'h0B;
   localparam logic [7:0] ADDR_DIE_LOW_LIM   = 8'h0C;
   localparam logic [7:0] ADDR_DIE_HIGH_LIM  = 8'h0D;
   localparam logic [7:0] ADDR_STATUS        = 8'h0E;
   localparam logic [7:0] ADDR_CURRENT_CMD   = 8'h0F;

   // =========================================
   // Field positions
   localparam int CTRL_HOLD_BIT     = 0;
   localparam int CTRL_COUNT_EN_BIT = 1;
   localparam int ALERT_UPPER_BIT   = 0;
   localparam int ALERT_LOWER_BIT   = 1;
   localparam int ALERT_DIE_LOW_BIT = 2;
   localparam int ALERT_DIE_HI_BIT  = 3;
   localparam int ALERT_COUNT       = 4;
   localparam int STAT_CHARGING_BIT = 0;
   localparam int STAT_RAMPING_BIT  = 1;
   localparam int STAT_ALERT_BIT    = 2;

   // =========================================
   // Reset values and range limits
   localparam logic [15:0] CONTROL_RESET     = 16'h0000;
   localparam logic [3:0]  ALERT_EN_RESET    = 4'h0;
   localparam logic [15:0] ACCUM_RESET       = 16'h0000;
   localparam logic [15:0] ACCUM_MAX         = 16'hFFFF;
   localparam logic [15:0] ACCUM_MIN         = 16'h0000;
   localparam logic [15:0] PRESCALE_RESET    = 16'h0200;
   localparam logic [15:0] PRESCALE_MIN      = 16'h0001;
   localparam logic [15:0] UPPER_LIM_RESET   = 16'hFFFF;
   localparam logic [15:0] LOWER_LIM_RESET   = 16'h0000;
   localparam logic [15:0] TARGET_RESET      = 16'h0000;
   localparam logic [15:0] DIE_LOW_RESET     = 16'h0000;
   localparam logic [15:0] DIE_HIGH_RESET    = 16'hFFFF;
   localparam logic [15:0] ZERO16            = 16'h0000;

   // =========================================
   // Timing
   localparam int CLK_PERIOD_NS        = 10;
   localparam int SOFT_START_STEP_NS   = 1000;
   localparam int SOFT_START_STEP_CYC  = (SOFT_START_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] RAMP_STEP   = 16'h0010;
endpackage
`default_nettype wire

// [logic/cca_limit_alert.sv]
`timescale 1ns/1ps
`default_nettype none
module cca_limit_alert #(
   parameter bit ABOVE = 1'b1
) (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic [15:0] value,
   input  wire logic [15:0] limit,
   input  wire logic        enable,
   input  wire logic        clear,
   output var  logic        flag
);
   import cca_pkg::*;

   logic crossed;
   logic flag_next;

   assign crossed   = ABOVE ? (value > limit) : (value < limit);
   // Set beats a clear in the same cycle so no crossing is lost
   assign flag_next = (enable & crossed) | (flag & ~clear);

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         flag <= 1'b0;
      end else begin
         flag <= flag_next;
      end
   end
endmodule // cca_limit_alert
`default_nettype wire

// [logic/cca_soft_start.sv]
`timescale 1ns/1ps
`default_nettype none
module cca_soft_start (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        chargeOn,
   input  wire logic [15:0] target,
   output var  logic [15:0] currentCmd,
   output var  logic        ramping
);
   import cca_pkg::*;

   localparam logic [15:0] STEP_LAST = 16'(SOFT_START_STEP_CYC - 1);

   logic [15:0] stepTimer_reg;
   logic [15:0] stepTimer_next;
   logic [15:0] cmd_next;
   logic [15:0] gap;
   logic        stepDue;

   assign gap            = target - currentCmd;
   assign stepDue        = (stepTimer_reg == STEP_LAST);
   assign stepTimer_next = (!chargeOn || stepDue) ? ZERO16 : stepTimer_reg + 16'h0001;
   // Falling target is followed at once; only rises are slewed
   assign cmd_next = !chargeOn               ? ZERO16 :
                     (currentCmd > target)   ? target :
                     !stepDue                ? currentCmd :
                     (gap > RAMP_STEP)       ? currentCmd + RAMP_STEP : target;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         stepTimer_reg <= ZERO16;
         currentCmd    <= ZERO16;
         ramping       <= 1'b0;
      end else begin
         stepTimer_reg <= stepTimer_next;
         currentCmd    <= cmd_next;
         ramping       <= chargeOn & (cmd_next != target);
      end
   end
endmodule // cca_soft_start
`default_nettype wire

// [logic/cca_charge_accumulator.sv]
`timescale 1ns/1ps
`default_nettype none
module cca_charge_accumulator (
   input  wire logic                 clk_sys,
   input  wire logic                 resetn,
   input  wire logic [7:0]           regAddr,
   input  wire logic [15:0]          regWrData,
   input  wire logic                 regWr,
   input  wire logic                 regRd,
   output var  logic [15:0]          regRdData,
   input  wire logic                 tickUp,
   input  wire logic                 tickDown,
   input  wire logic                 telemetryValid,
   input  wire logic [15:0]          batVoltageIn,
   input  wire logic [15:0]          chargeCurrentIn,
   input  wire logic [15:0]          inputCurrentIn,
   input  wire logic                 dieTempValid,
   input  wire logic [15:0]          dieTempIn,
   output var  logic                 smbAlertN,
   output var  logic                 chargeEnable,
   output var  logic [15:0]          chargeCurrentCmd
);
   import cca_pkg::*;

   // =========================================
   // Register storage
   logic [15:0] control_reg;
   logic [3:0]  alertEnable_reg;
   logic [15:0] accumulator_reg;
   logic [15:0] accumulator_next;
   logic [15:0] upperLimit_reg;
   logic [15:0] lowerLimit_reg;
   logic [15:0] prescale_reg;
   logic [15:0] prescale_next;
   logic [15:0] chargeTarget_reg;
   logic [15:0] batVoltage_reg;
   logic [15:0] chargeCurrent_reg;
   logic [15:0] inputCurrent_reg;
   logic [15:0] dieTemp_reg;
   logic [15:0] dieLowLimit_reg;
   logic [15:0] dieHighLimit_reg;
   logic [15:0] preCount_reg;
   logic [15:0] preCount_next;
   logic [15:0] rdData_next;

   // =========================================
   // Address decode
   logic wrControl;
   logic wrAlertEnable;
   logic wrAlertFlags;
   logic wrAccumulator;
   logic wrUpperLimit;
   logic wrLowerLimit;
   logic wrPrescale;
   logic wrChargeTarget;
   logic wrDieLowLimit;
   logic wrDieHighLimit;

   assign wrControl      = regWr & (regAddr == ADDR_CONTROL);
   assign wrAlertEnable  = regWr & (regAddr == ADDR_ALERT_ENABLE);
   assign wrAlertFlags   = regWr & (regAddr == ADDR_ALERT_FLAGS);
   assign wrAccumulator  = regWr & (regAddr == ADDR_ACCUMULATOR);
   assign wrUpperLimit   = regWr & (regAddr == ADDR_UPPER_LIMIT);
   assign wrLowerLimit   = regWr & (regAddr == ADDR_LOWER_LIMIT);
   assign wrPrescale     = regWr & (regAddr == ADDR_PRESCALE);
   assign wrChargeTarget = regWr & (regAddr == ADDR_CHARGE_TARGET);
   assign wrDieLowLimit  = regWr & (regAddr == ADDR_DIE_LOW_LIM);
   assign wrDieHighLimit = regWr & (regAddr == ADDR_DIE_HIGH_LIM);

   // =========================================
   // Control bits
   logic holdCharger;
   logic countEnable;
   logic chargeOn;

   assign holdCharger = control_reg[CTRL_HOLD_BIT];
   assign countEnable = control_reg[CTRL_COUNT_EN_BIT];
   assign chargeOn    = ~holdCharger;

   // =========================================
   // Prescaler
   logic [15:0] preLast;
   logic        tickUpEn;
   logic        tickDownEn;
   logic        stepUp;
   logic        stepDown;

   // Opposite ticks in one cycle cancel out
   assign tickUpEn   = countEnable & tickUp & ~tickDown;
   assign tickDownEn = countEnable & tickDown & ~tickUp;
   assign preLast    = prescale_reg - 16'h0001;
   assign stepUp     = tickUpEn & (preCount_reg == preLast);
   assign stepDown   = tickDownEn & (preCount_reg == ZERO16);
   // A new factor restarts the phase so the count never sits past the end
   assign preCount_next = (wrPrescale || !countEnable) ? ZERO16 :
                          stepUp                       ? ZERO16 :
                          stepDown                     ? preLast :
                          tickUpEn                     ? preCount_reg + 16'h0001 :
                          tickDownEn                   ? preCount_reg - 16'h0001 :
                                                         preCount_reg;
   // Zero is outside the legal range and is taken as one
   assign prescale_next = (regWrData == ZERO16) ? PRESCALE_MIN : regWrData;

   // =========================================
   // Accumulator
   logic atMax;
   logic atMin;

   assign atMax = (accumulator_reg == ACCUM_MAX);
   assign atMin = (accumulator_reg == ACCUM_MIN);
   // Host write wins over a step in the same cycle
   assign accumulator_next = wrAccumulator         ? regWrData :
                             (stepUp && !atMax)    ? accumulator_reg + 16'h0001 :
                             (stepDown && !atMin)  ? accumulator_reg - 16'h0001 :
                                                     accumulator_reg;

   // =========================================
   // Limit alerts
   logic [3:0] alertFlags;
   logic [3:0] flagClear;
   logic       alertActive;

   assign flagClear   = wrAlertFlags ? regWrData[3:0] : 4'h0;
   assign alertActive = |(alertFlags & alertEnable_reg);

   cca_limit_alert #(.ABOVE(1'b1)) u_upperAlert (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .value   (accumulator_reg),
      .limit   (upperLimit_reg),
      .enable  (alertEnable_reg[ALERT_UPPER_BIT]),
      .clear   (flagClear[ALERT_UPPER_BIT]),
      .flag    (alertFlags[ALERT_UPPER_BIT])
   );

   cca_limit_alert #(.ABOVE(1'b0)) u_lowerAlert (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .value   (accumulator_reg),
      .limit   (lowerLimit_reg),
      .enable  (alertEnable_reg[ALERT_LOWER_BIT]),
      .clear   (flagClear[ALERT_LOWER_BIT]),
      .flag    (alertFlags[ALERT_LOWER_BIT])
   );

   cca_limit_alert #(.ABOVE(1'b0)) u_dieLowAlert (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .value   (dieTemp_reg),
      .limit   (dieLowLimit_reg),
      .enable  (alertEnable_reg[ALERT_DIE_LOW_BIT]),
      .clear   (flagClear[ALERT_DIE_LOW_BIT]),
      .flag    (alertFlags[ALERT_DIE_LOW_BIT])
   );

   cca_limit_alert #(.ABOVE(1'b1)) u_dieHighAlert (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .value   (dieTemp_reg),
      .limit   (dieHighLimit_reg),
      .enable  (alertEnable_reg[ALERT_DIE_HI_BIT]),
      .clear   (flagClear[ALERT_DIE_HI_BIT]),
      .flag    (alertFlags[ALERT_DIE_HI_BIT])
   );

   // =========================================
   // Soft start
   logic [15:0] rampCmd;
   logic        rampBusy;

   cca_soft_start u_softStart (
      .clk_sys    (clk_sys),
      .resetn     (resetn),
      .chargeOn   (chargeOn),
      .target     (chargeTarget_reg),
      .currentCmd (rampCmd),
      .ramping    (rampBusy)
   );

   // =========================================
   // Read mux
   logic [15:0] statusWord;

   assign statusWord = {13'h0000, alertActive, rampBusy, chargeOn};
   assign rdData_next = !regRd                            ? ZERO16 :
                        (regAddr == ADDR_CONTROL)         ? control_reg :
                        (regAddr == ADDR_ALERT_ENABLE)    ? {12'h000, alertEnable_reg} :
                        (regAddr == ADDR_ALERT_FLAGS)     ? {12'h000, alertFlags} :
                        (regAddr == ADDR_ACCUMULATOR)     ? accumulator_reg :
                        (regAddr == ADDR_UPPER_LIMIT)     ? upperLimit_reg :
                        (regAddr == ADDR_LOWER_LIMIT)     ? lowerLimit_reg :
                        (regAddr == ADDR_PRESCALE)        ? prescale_reg :
                        (regAddr == ADDR_CHARGE_TARGET)   ? chargeTarget_reg :
                        (regAddr == ADDR_BAT_VOLTAGE)     ? batVoltage_reg :
                        (regAddr == ADDR_CHARGE_CURR)     ? chargeCurrent_reg :
                        (regAddr == ADDR_INPUT_CURR)      ? inputCurrent_reg :
                        (regAddr == ADDR_DIE_TEMP)        ? dieTemp_reg :
                        (regAddr == ADDR_DIE_LOW_LIM)     ? dieLowLimit_reg :
                        (regAddr == ADDR_DIE_HIGH_LIM)    ? dieHighLimit_reg :
                        (regAddr == ADDR_STATUS)          ? statusWord :
                        (regAddr == ADDR_CURRENT_CMD)     ? rampCmd :
                                                            ZERO16;

   // =========================================
   // Host registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         control_reg      <= CONTROL_RESET;
         alertEnable_reg  <= ALERT_EN_RESET;
         upperLimit_reg   <= UPPER_LIM_RESET;
         lowerLimit_reg   <= LOWER_LIM_RESET;
         chargeTarget_reg <= TARGET_RESET;
         dieLowLimit_reg  <= DIE_LOW_RESET;
         dieHighLimit_reg <= DIE_HIGH_RESET;
      end else begin
         if (wrControl) control_reg <= {14'h0000, regWrData[1:0]};
         if (wrAlertEnable) alertEnable_reg <= regWrData[3:0];
         if (wrUpperLimit) upperLimit_reg <= regWrData;
         if (wrLowerLimit) lowerLimit_reg <= regWrData;
         if (wrChargeTarget) chargeTarget_reg <= regWrData;
         if (wrDieLowLimit) dieLowLimit_reg <= regWrData;
         if (wrDieHighLimit) dieHighLimit_reg <= regWrData;
      end
   end

   // =========================================
   // Counter state
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         prescale_reg    <= PRESCALE_RESET;
         preCount_reg    <= ZERO16;
         accumulator_reg <= ACCUM_RESET;
      end else begin
         if (wrPrescale) prescale_reg <= prescale_next;
         preCount_reg    <= preCount_next;
         accumulator_reg <= accumulator_next;
      end
   end

   // =========================================
   // Telemetry capture
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         batVoltage_reg    <= ZERO16;
         chargeCurrent_reg <= ZERO16;
         inputCurrent_reg  <= ZERO16;
         dieTemp_reg       <= ZERO16;
      end else begin
         if (telemetryValid) begin
            batVoltage_reg    <= batVoltageIn;
            chargeCurrent_reg <= chargeCurrentIn;
            inputCurrent_reg  <= inputCurrentIn;
         end
         if (dieTempValid) dieTemp_reg <= dieTempIn;
      end
   end

   // =========================================
   // Outputs
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         regRdData        <= ZERO16;
         smbAlertN        <= 1'b1;
         chargeEnable     <= 1'b0;
         chargeCurrentCmd <= ZERO16;
      end else begin
         regRdData        <= rdData_next;
         smbAlertN        <= ~alertActive;
         chargeEnable     <= chargeOn;
         chargeCurrentCmd <= rampCmd;
      end
   end
endmodule // cca_charge_accumulator
`default_nettype wire

// [tb/cca_checker_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module cca_checker (
   input wire logic        clk_sys,
   input wire logic        resetn,
   input wire logic [7:0]  regAddr,
   input wire logic [15:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [15:0] regRdData,
   input wire logic        tickUp,
   input wire logic        tickDown,
   input wire logic        smbAlertN,
   input wire logic        chargeEnable,
   input wire logic [15:0] chargeCurrentCmd
);
   import cca_pkg::*;
   // ==========================================
   // Port properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   rst_state_a: assert property (@(posedge clk_sys) disable iff (1'b0) !resetn |=> smbAlertN && !chargeEnable
      && chargeCurrentCmd == ZERO16 && regRdData == ZERO16) else $error("outputs not reset");
   rd_idle_a: assert property (!$past(regRd) |-> regRdData == ZERO16) else $error("read data outside slot");
   unmapped_rd_a: assert property (regRd && regAddr > ADDR_CURRENT_CMD |=> regRdData == ZERO16)
      else $error("unmapped read not zero");
   // Gap cycle free of ticks so no step can race the overwrite
   acc_write_a: assert property ((regWr && regAddr == ADDR_ACCUMULATOR) ##1 (!tickUp && !tickDown)
      ##1 (regRd && regAddr == ADDR_ACCUMULATOR && !tickUp && !tickDown)
      |=> regRdData == $past(regWrData, 3)) else $error("accumulator overwrite lost");
   hold_set_a: assert property (regWr && regAddr == ADDR_CONTROL && regWrData[CTRL_HOLD_BIT]
      |-> ##[1:2] !chargeEnable) else $error("hold did not stop charging");
   hold_clr_a: assert property (regWr && regAddr == ADDR_CONTROL && !regWrData[CTRL_HOLD_BIT]
      |-> ##[1:2] chargeEnable) else $error("charging did not resume");
   hold_cmd_a: assert property (!chargeEnable [*3] |-> chargeCurrentCmd == ZERO16)
      else $error("current commanded while held");
   ramp_step_a: assert property (chargeCurrentCmd > $past(chargeCurrentCmd)
      |-> chargeCurrentCmd - $past(chargeCurrentCmd) == RAMP_STEP) else $error("ramp step size");
   ramp_slow_a: assert property (chargeCurrentCmd > $past(chargeCurrentCmd) |=> $stable(chargeCurrentCmd) [*8])
      else $error("ramp too fast");
   alert_rel_a: assert property ($rose(smbAlertN) |-> $past(regWr) || $past(regWr, 2))
      else $error("alert released without host write");
endmodule // cca_checker
`default_nettype wire

// [tb/cca_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cca_host_model (
   input  wire logic        clk_sys,
   input  wire logic [15:0] regRdData,
   output var  logic [7:0]  regAddr,
   output var  logic [15:0] regWrData,
   output var  logic        regWr,
   output var  logic        regRd
);
   import cca_pkg::*;
   // ==========================================
   // Bus cycles
   initial begin
      regAddr = 8'h00;
      regWrData = 16'h0000;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   // Data taken inside its single valid cycle
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   // ==========================================
   // Alert service
   task automatic service_upper(input logic [15:0] recharge);
      logic [15:0] f;
      rd(ADDR_ALERT_FLAGS, f);
      if (f[ALERT_UPPER_BIT] === 1'b1) begin
         wr(ADDR_CONTROL, 16'h0003);
         wr(ADDR_LOWER_LIMIT, recharge);
         wr(ADDR_ALERT_ENABLE, 16'h0002);
      end
   endtask
   task automatic service_lower();
      logic [15:0] f;
      rd(ADDR_ALERT_FLAGS, f);
      if (f[ALERT_LOWER_BIT] === 1'b1) begin
         wr(ADDR_ALERT_ENABLE, 16'h0001);
         wr(ADDR_CONTROL, 16'h0002);
      end
   endtask
endmodule // cca_host_model
`default_nettype wire

// [tb/charge_accumulator_alerts_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module charge_accumulator_alerts_bench;
   import cca_pkg::*;
   // ==========================================
   // Signals and model state
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  regAddr;
   logic [15:0] regWrData, regRdData, chargeCurrentCmd;
   logic        regWr, regRd, smbAlertN, chargeEnable;
   logic        tickUp = 1'b0, tickDown = 1'b0, telemetryValid = 1'b0, dieTempValid = 1'b0;
   logic [15:0] batVoltageIn = 16'h0000, chargeCurrentIn = 16'h0000, inputCurrentIn = 16'h0000;
   logic [15:0] dieTempIn = 16'h0000;
   logic [15:0] tel [3];
   int          n_fail = 0, samples_checked = 0, acc = 0, ph = 0, ps = 512;
   localparam logic [7:0]  RA [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D,
                                      8'h10, 8'hFF};
   localparam logic [15:0] RX [12] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0200,
                                      16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
   always #5 clk_sys = ~clk_sys;
   cca_charge_accumulator i_dut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tickUp(tickUp), .tickDown(tickDown),
      .telemetryValid(telemetryValid), .batVoltageIn(batVoltageIn), .chargeCurrentIn(chargeCurrentIn),
      .inputCurrentIn(inputCurrentIn), .dieTempValid(dieTempValid), .dieTempIn(dieTempIn),
      .smbAlertN(smbAlertN), .chargeEnable(chargeEnable), .chargeCurrentCmd(chargeCurrentCmd));
   cca_host_model i_host (.clk_sys(clk_sys), .regRdData(regRdData), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd));
   // ==========================================
   // Tasks
   task automatic close_out();
      if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [15:0] exp);
      logic [15:0] got;
      i_host.rd(a, got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: register %h read %h, expected %h", $time, a, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: output %h, expected %h", $time, got, exp);
      end
   endtask
   // Pin settles three edges after its cause
   task automatic settle();
      repeat (3) @(posedge clk_sys);
      #1;
   endtask
   task automatic wra(input logic [15:0] v);
      i_host.wr(ADDR_ACCUMULATOR, v);
      acc = v;
   endtask
   task automatic wrp(input logic [15:0] v);
      i_host.wr(ADDR_PRESCALE, v);
      ps = (v == 16'h0000) ? 1 : int'(v);
      ph = 0;
   endtask
   // Mode 0 random, 1 up, 2 down; back to back ticks
   task automatic tick(input int n, input int mode);
      logic u, d;
      repeat (n) begin
         u = (mode == 1) || (mode == 0 && $urandom % 2 == 1);
         d = (mode == 2) || (mode == 0 && $urandom % 2 == 1);
         @(posedge clk_sys);
         tickUp <= u;
         tickDown <= d;
         if (u && !d) begin
            if (ph == ps - 1) begin
               ph = 0;
               if (acc < 65535) acc++;
            end else ph++;
         end else if (d && !u) begin
            if (ph == 0) begin
               ph = ps - 1;
               if (acc > 0) acc--;
            end else ph--;
         end
      end
      @(posedge clk_sys);
      tickUp <= 1'b0;
      tickDown <= 1'b0;
   endtask
   // ==========================================
   // Tests
   initial begin
      void'($urandom(32'h2971));
      repeat (6) @(posedge clk_sys);
      resetn <= 1'b1;
      for (int i = 0; i < 12; i++) chk_reg(RA[i], RX[i]);
      i_host.wr(ADDR_CONTROL, 16'h0002);
      tick(511, 1);
      chk_reg(ADDR_ACCUMULATOR, 16'h0000);
      tick(1, 1);
      chk_reg(ADDR_ACCUMULATOR, 16'h0001);
      wrp(16'h0003);
      wra(16'h0100);
      tick(200, 0);
      chk_reg(ADDR_ACCUMULATOR, 16'(acc));
      wra(16'($urandom));
      chk_reg(ADDR_ACCUMULATOR, 16'(acc));
      wrp(16'h0000);
      chk_reg(ADDR_PRESCALE, 16'h0001);
      wra(16'hFFFE);
      tick(4, 1);
      chk_reg(ADDR_ACCUMULATOR, 16'hFFFF);
      wra(16'h0001);
      tick(4, 2);
      chk_reg(ADDR_ACCUMULATOR, 16'h0000);
      i_host.wr(ADDR_CHARGE_TARGET, 16'h0030);
      repeat (400) @(posedge clk_sys);
      #1 chk_out(chargeCurrentCmd, 16'h0030);
      chk_reg(ADDR_CURRENT_CMD, 16'h0030);
      chk_reg(ADDR_STATUS, 16'h0001);
      wra(16'h0100);
      i_host.wr(ADDR_UPPER_LIMIT, 16'h0102);
      i_host.wr(ADDR_ALERT_ENABLE, 16'h0001);
      tick(2, 1);
      settle();
      chk_out(16'(smbAlertN), 16'h0001);
      tick(1, 1);
      settle();
      chk_out(16'(smbAlertN), 16'h0000);
      i_host.service_upper(16'h00FF);
      settle();
      chk_out(16'(chargeEnable), 16'h0000);
      chk_out(chargeCurrentCmd, 16'h0000);
      chk_out(16'(smbAlertN), 16'h0001);
      chk_reg(ADDR_ALERT_FLAGS, 16'h0001);
      i_host.wr(ADDR_ALERT_FLAGS, 16'h0001);
      chk_reg(ADDR_ALERT_FLAGS, 16'h0000);
      tick(4, 2);
      settle();
      chk_out(16'(smbAlertN), 16'h0001);
      tick(1, 2);
      settle();
      chk_out(16'(smbAlertN), 16'h0000);
      chk_reg(ADDR_ALERT_FLAGS, 16'h0002);
      i_host.service_lower();
      settle();
      chk_out(16'(chargeEnable), 16'h0001);
      chk_out(16'(smbAlertN), 16'h0001);
      repeat (17) @(posedge clk_sys);
      #1 chk_out(16'(chargeCurrentCmd <= 16'h0010), 16'h0001);
      i_host.wr(ADDR_ALERT_FLAGS, 16'h000F);
      for (int i = 0; i < 3; i++) tel[i] = 16'($urandom);
      @(posedge clk_sys);
      {batVoltageIn, chargeCurrentIn, inputCurrentIn} <= {tel[0], tel[1], tel[2]};
      {telemetryValid, dieTempValid, dieTempIn} <= {2'b11, 16'h0200};
      @(posedge clk_sys);
      {telemetryValid, dieTempValid, batVoltageIn, dieTempIn} <= {2'b00, ~tel[0], 16'h0001};
      for (int i = 0; i < 3; i++) chk_reg(8'(ADDR_BAT_VOLTAGE + i), tel[i]);
      i_host.wr(ADDR_DIE_TEMP, 16'h1234);
      chk_reg(ADDR_DIE_TEMP, 16'h0200);
      i_host.wr(ADDR_DIE_HIGH_LIM, 16'h0100);
      i_host.wr(ADDR_DIE_LOW_LIM, 16'h0300);
      chk_reg(ADDR_ALERT_FLAGS, 16'h0000);
      i_host.wr(ADDR_ALERT_ENABLE, 16'h000D);
      settle();
      chk_out(16'(smbAlertN), 16'h0000);
      // Reading sits below the low limit and above the high limit, both enabled
      chk_reg(ADDR_ALERT_FLAGS, 16'h000C);
      // Ramp restarted after the hold was lifted and is still climbing here
      chk_reg(ADDR_STATUS, 16'h0007);
      close_out();
   end
   initial begin
      #400_000;
      n_fail++;
      close_out();
   end
endmodule // charge_accumulator_alerts_bench
bind cca_charge_accumulator cca_checker i_chk (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .tickUp(tickUp),
   .tickDown(tickDown), .smbAlertN(smbAlertN), .chargeEnable(chargeEnable), .chargeCurrentCmd(chargeCurrentCmd));
`default_nettype wire
